// ===== logic/iplr_priority_regs.sv
// priority level registers with wishbone slave and arbitration front end
// ==========================================================
// What this block does
// - A debug source field reads 00 as off and 01, 10, 11 as levels 1, 2 and 3.
// - A peripheral or system field reads 00 as off and 01, 10, 11 as levels 0, 1, 2.
// - Every priority field is 00 after reset so all sources start off.
// - Unused bits of the priority registers read zero and ignore writes.
// - Debug event register: breakpoint at 13-12, step count at 11-10, 9-0 unused.
// - Debug channel register: 15-6 unused, receive 5-4, transmit 3-2, trace 1-0.
// - System register: flash buffers empty 15-14, command done 13-12, error 11-10.
// - System register: pll lock lost at 9-8, low voltage at 7-6, 5-4 unused.
// - System register: external request b at 3-2 and a at 1-0, levels 0 to 2.
// - Port register: ports d, e and f at 15-14, 13-12 and 11-10.
// - System and port registers reset to zero in all sixteen bits.
// - Port register: can buffer 9-8, wake 7-6, fault 5-4, bus off 3-2, 1-0 unused.
// - The vector address is the vector base joined with the winning vector number.
`timescale 1ns/1ns
`default_nettype none
module iplr_priority_regs
  import iplr_pkg::*;
#(
  parameter int ADR_W = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_SRC-1:0] irqPending,
  output logic irqRequest,
  output logic [LVL_W-1:0] irqLevel,
  output logic [VEC_W-1:0] irqVector,
  output logic [VBA_W+VEC_W-1:0] irqVectorAddr
);
  // ==========================================================
  // declarations
  logic ack_r;
  logic [DATA_W-1:0] rdData_r;
  logic [DATA_W-1:0] rdData_nxt;
  logic [REG_W-1:0] prio_r [NUM_PRIO];
  logic [VBA_W-1:0] vectorBase_r;
  logic reqHit;
  logic wrFire;
  logic rdLatch;
  logic [IDX_W-1:0] regIdx;
  logic [REG_W-1:0] laneMask;
  logic [NUM_SRC-1:0] srcEnable;
  logic [2*NUM_SRC-1:0] srcLevel;
  logic winValid;
  logic [VEC_W-1:0] winIndex;
  logic [LVL_W-1:0] winLevel;
  logic irqRequest_r;
  logic [LVL_W-1:0] irqLevel_r;
  logic [VEC_W-1:0] irqVector_r;
  logic [VBA_W+VEC_W-1:0] irqVectorAddr_r;

  // ==========================================================
  // bus handshake: one wait state, ack for exactly one cycle
  assign reqHit = wb_cyc_i & wb_stb_i;
  assign regIdx = wb_adr_i[ADR_W-1:2];
  // write lands on the edge that samples ack, as the master expects
  assign wrFire = reqHit & wb_we_i & ack_r;
  assign rdLatch = reqHit & ~ack_r;
  assign laneMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= reqHit & ~ack_r;
    end
  end

  assign wb_ack_o = ack_r;

  // ==========================================================
  // priority registers
  genvar g;
  generate
    for (g = 0; g < NUM_PRIO; g++) begin : gPrio
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          prio_r[g] <= RESET_PRIORITY;
        end else if (wrFire && regIdx == PRIO_IDX[g]) begin
          // only implemented bits accept data
          prio_r[g] <= (prio_r[g] & ~(laneMask & PRIO_MASK[g]))
                     | (wb_dat_i[REG_W-1:0] & laneMask & PRIO_MASK[g]);
        end
      end
    end
  endgenerate

  // ==========================================================
  // vector base register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      vectorBase_r <= RESET_VECTOR_BASE;
    end else if (wrFire && regIdx == IDX_VECTOR_BASE) begin
      vectorBase_r <= (vectorBase_r & ~laneMask) | (wb_dat_i[VBA_W-1:0] & laneMask);
    end
  end

  // ==========================================================
  // read path: unmapped indexes answer zero
  always_comb begin
    rdData_nxt = '0;
    if (regIdx == IDX_DEBUG_EVENT) begin
      rdData_nxt[REG_W-1:0] = prio_r[0] & PRIO_MASK[0];
    end else if (regIdx == IDX_DEBUG_CHANNEL) begin
      rdData_nxt[REG_W-1:0] = prio_r[1] & PRIO_MASK[1];
    end else if (regIdx == IDX_SYSTEM_EVENT) begin
      rdData_nxt[REG_W-1:0] = prio_r[2] & PRIO_MASK[2];
    end else if (regIdx == IDX_PORT_AND_CAN) begin
      rdData_nxt[REG_W-1:0] = prio_r[3] & PRIO_MASK[3];
    end else if (regIdx == IDX_VECTOR_BASE) begin
      rdData_nxt[VBA_W-1:0] = vectorBase_r;
    end else if (regIdx == IDX_ARB_STATUS) begin
      rdData_nxt[STAT_VEC_LSB +: VEC_W] = irqVector_r;
      rdData_nxt[STAT_LVL_LSB +: LVL_W] = irqLevel_r;
      rdData_nxt[STAT_REQ_BIT] = irqRequest_r;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdData_r <= '0;
    end else if (rdLatch) begin
      rdData_r <= rdData_nxt;
    end
  end

  assign wb_dat_o = rdData_r;

  // ==========================================================
  // field extraction and decode per source
  genvar s;
  generate
    for (s = 0; s < NUM_SRC; s++) begin : gSrc
      logic [FIELD_W-1:0] fieldCode;
      logic [LVL_W:0] decoded;
      // placement tables carry the bit positions of every field
      assign fieldCode = prio_r[SRC_REG[s]][SRC_LSB[s] +: FIELD_W];
      // debug sources sit first in the table
      assign decoded = iplr_decode(fieldCode, (s < NUM_DBG));
      assign srcEnable[s] = decoded[LVL_W];
      assign srcLevel[2*s +: 2] = decoded[LVL_W-1:0];
    end
  endgenerate

  // ==========================================================
  // arbitration; fields are read straight from the registers
  iplr_arbiter #(
    .N(NUM_SRC)
  ) u_arbiter (
    .srcPending(irqPending),
    .srcEnable(srcEnable),
    .srcLevel(srcLevel),
    .winValid(winValid),
    .winIndex(winIndex),
    .winLevel(winLevel)
  );

  // result registered: one cycle from pending to request
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irqRequest_r <= 1'b0;
      irqLevel_r <= '0;
      irqVector_r <= '0;
    end else begin
      irqRequest_r <= winValid;
      irqLevel_r <= winLevel;
      irqVector_r <= winIndex;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irqVectorAddr_r <= '0;
    end else begin
      irqVectorAddr_r <= {vectorBase_r, winIndex};
    end
  end

  assign irqRequest = irqRequest_r;
  assign irqLevel = irqLevel_r;
  assign irqVector = irqVector_r;
  assign irqVectorAddr = irqVectorAddr_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  AST_RESERVED_ZERO: assert property (
    ((prio_r[0] & ~PRIO_MASK[0]) == '0) && ((prio_r[1] & ~PRIO_MASK[1]) == '0)
    && ((prio_r[2] & ~PRIO_MASK[2]) == '0) && ((prio_r[3] & ~PRIO_MASK[3]) == '0))
    else $error("reserved priority bit set");

  AST_DEBUG_LEVEL_MAP: assert property (
    (prio_r[0][13:12] != FIELD_OFF)
    |-> (srcEnable[0] && srcLevel[1:0] == prio_r[0][13:12]))
    else $error("breakpoint level decoded wrongly");

  AST_PERIPH_LEVEL_MAP: assert property (
    (prio_r[2][1:0] != FIELD_OFF)
    |-> (srcEnable[11] && srcLevel[23:22] == LVL_W'(prio_r[2][1:0] - 2'h1)
         && srcLevel[23:22] <= PERIPH_LEVEL_TOP))
    else $error("external request a level decoded wrongly");

  AST_OFF_NOT_ENABLED: assert property (
    (prio_r[3][15:14] == FIELD_OFF) |-> !srcEnable[12])
    else $error("disabled port d field still enabled");

  AST_WRITE_LANDS: assert property (
    (wrFire && regIdx == IDX_SYSTEM_EVENT && wb_sel_i[1:0] == 2'h3)
    |=> (prio_r[2] == ($past(wb_dat_i[REG_W-1:0]) & PRIO_MASK[2])))
    else $error("system register write did not land");

  AST_ACK_PULSE: assert property (
    ack_r |=> !ack_r)
    else $error("ack held longer than one cycle");

  AST_ACK_FOLLOWS: assert property (
    (reqHit && !ack_r) |=> ack_r)
    else $error("request not acknowledged next cycle");

  AST_VECTOR_JOIN: assert property (
    irqRequest_r |-> (irqVectorAddr_r[VEC_W-1:0] == irqVector_r
                      && irqVectorAddr_r[VBA_W+VEC_W-1:VEC_W] == $past(vectorBase_r)))
    else $error("vector address is not base joined with vector");

  AST_WINNER_LIVE: assert property (
    irqRequest_r |-> (($past(irqPending & srcEnable) & (NUM_SRC'(1) << irqVector_r)) != '0))
    else $error("winner was not an enabled pending source");

  AST_IDLE_QUIET: assert property (
    ((irqPending & srcEnable) == '0) |=> !irqRequest_r)
    else $error("request without enabled pending source");

  // fixed bit positions here, independent of the placement tables
  AST_STEP_LEVEL_MAP: assert property (
    (srcEnable[1] == (prio_r[0][11:10] != FIELD_OFF))
    && (!srcEnable[1] || srcLevel[3:2] == prio_r[0][11:10]))
    else $error("step count level decoded wrongly");

  AST_RECEIVE_LEVEL_MAP: assert property (
    (srcEnable[2] == (prio_r[1][5:4] != FIELD_OFF))
    && (!srcEnable[2] || srcLevel[5:4] == prio_r[1][5:4]))
    else $error("receive full level decoded wrongly");

  AST_TRANSMIT_LEVEL_MAP: assert property (
    (srcEnable[3] == (prio_r[1][3:2] != FIELD_OFF))
    && (!srcEnable[3] || srcLevel[7:6] == prio_r[1][3:2]))
    else $error("transmit empty level decoded wrongly");

  AST_TRACE_LEVEL_MAP: assert property (
    (srcEnable[4] == (prio_r[1][1:0] != FIELD_OFF))
    && (!srcEnable[4] || srcLevel[9:8] == prio_r[1][1:0]))
    else $error("trace level decoded wrongly");

  AST_FLASH_EMPTY_MAP: assert property (
    (srcEnable[5] == (prio_r[2][15:14] != FIELD_OFF))
    && (!srcEnable[5] || srcLevel[11:10] == LVL_W'(prio_r[2][15:14] - 2'h1)))
    else $error("flash buffers empty level decoded wrongly");

  AST_FLASH_DONE_MAP: assert property (
    (srcEnable[6] == (prio_r[2][13:12] != FIELD_OFF))
    && (!srcEnable[6] || srcLevel[13:12] == LVL_W'(prio_r[2][13:12] - 2'h1)))
    else $error("flash command done level decoded wrongly");

  AST_FLASH_ERROR_MAP: assert property (
    (srcEnable[7] == (prio_r[2][11:10] != FIELD_OFF))
    && (!srcEnable[7] || srcLevel[15:14] == LVL_W'(prio_r[2][11:10] - 2'h1)))
    else $error("flash error level decoded wrongly");

  AST_PLL_LEVEL_MAP: assert property (
    (srcEnable[8] == (prio_r[2][9:8] != FIELD_OFF))
    && (!srcEnable[8] || srcLevel[17:16] == LVL_W'(prio_r[2][9:8] - 2'h1)))
    else $error("pll lock lost level decoded wrongly");

  AST_LOW_VOLT_MAP: assert property (
    (srcEnable[9] == (prio_r[2][7:6] != FIELD_OFF))
    && (!srcEnable[9] || srcLevel[19:18] == LVL_W'(prio_r[2][7:6] - 2'h1)))
    else $error("low voltage level decoded wrongly");

  AST_EXT_B_LEVEL_MAP: assert property (
    (srcEnable[10] == (prio_r[2][3:2] != FIELD_OFF))
    && (!srcEnable[10] || srcLevel[21:20] == LVL_W'(prio_r[2][3:2] - 2'h1)))
    else $error("external request b level decoded wrongly");

  AST_PORT_D_LEVEL_MAP: assert property (
    (srcEnable[12] == (prio_r[3][15:14] != FIELD_OFF))
    && (!srcEnable[12] || srcLevel[25:24] == LVL_W'(prio_r[3][15:14] - 2'h1)))
    else $error("port d level decoded wrongly");

  AST_PORT_E_LEVEL_MAP: assert property (
    (srcEnable[13] == (prio_r[3][13:12] != FIELD_OFF))
    && (!srcEnable[13] || srcLevel[27:26] == LVL_W'(prio_r[3][13:12] - 2'h1)))
    else $error("port e level decoded wrongly");

  AST_PORT_F_LEVEL_MAP: assert property (
    (srcEnable[14] == (prio_r[3][11:10] != FIELD_OFF))
    && (!srcEnable[14] || srcLevel[29:28] == LVL_W'(prio_r[3][11:10] - 2'h1)))
    else $error("port f level decoded wrongly");

  AST_CAN_MSG_LEVEL_MAP: assert property (
    (srcEnable[15] == (prio_r[3][9:8] != FIELD_OFF))
    && (!srcEnable[15] || srcLevel[31:30] == LVL_W'(prio_r[3][9:8] - 2'h1)))
    else $error("can buffer level decoded wrongly");

  AST_CAN_WAKE_LEVEL_MAP: assert property (
    (srcEnable[16] == (prio_r[3][7:6] != FIELD_OFF))
    && (!srcEnable[16] || srcLevel[33:32] == LVL_W'(prio_r[3][7:6] - 2'h1)))
    else $error("can wake level decoded wrongly");

  AST_CAN_FAULT_LEVEL_MAP: assert property (
    (srcEnable[17] == (prio_r[3][5:4] != FIELD_OFF))
    && (!srcEnable[17] || srcLevel[35:34] == LVL_W'(prio_r[3][5:4] - 2'h1)))
    else $error("can fault level decoded wrongly");

  AST_CAN_BUS_OFF_MAP: assert property (
    (srcEnable[18] == (prio_r[3][3:2] != FIELD_OFF))
    && (!srcEnable[18] || srcLevel[37:36] == LVL_W'(prio_r[3][3:2] - 2'h1)))
    else $error("can bus off level decoded wrongly");

  AST_READ_SYSTEM: assert property (
    (rdLatch && regIdx == IDX_SYSTEM_EVENT)
    |=> (wb_dat_o[REG_W-1:0] == ($past(prio_r[2]) & PRIO_MASK[2]) && wb_dat_o[DATA_W-1:REG_W] == '0))
    else $error("system register read data wrong");

  AST_PERIPH_LEVEL_CAP: assert property (
    (irqRequest_r && irqVector_r >= VEC_W'(NUM_DBG)) |-> irqLevel_r <= PERIPH_LEVEL_TOP)
    else $error("peripheral source above its top level");

  AST_DEBUG_LEVEL_FLOOR: assert property (
    (irqRequest_r && irqVector_r < VEC_W'(NUM_DBG)) |-> irqLevel_r != 2'h0)
    else $error("debug source reported at level zero");

endmodule : iplr_priority_regs
`default_nettype wire

// ===== logic/iplr_pkg.sv
// shared constants for the interrupt priority level registers
package iplr_pkg;
  // ==========================================================
  // widths and counts
  localparam int REG_W = 16;
  localparam int DATA_W = 32;
  localparam int LVL_W = 2;
  localparam int VEC_W = 7;
  localparam int IDX_W = 6;
  localparam int NUM_PRIO = 4;
  localparam int NUM_SRC = 19;
  localparam int NUM_DBG = 5;
  localparam int FIELD_W = 2;
  localparam int VBA_W = 16;
  // ==========================================================
  // register indexes, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_DEBUG_EVENT = 6'h00;
  localparam logic [IDX_W-1:0] IDX_DEBUG_CHANNEL = 6'h01;
  localparam logic [IDX_W-1:0] IDX_SYSTEM_EVENT = 6'h02;
  localparam logic [IDX_W-1:0] IDX_PORT_AND_CAN = 6'h03;
  localparam logic [IDX_W-1:0] IDX_VECTOR_BASE = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_ARB_STATUS = 6'h20;
  localparam logic [IDX_W-1:0] PRIO_IDX [NUM_PRIO] = '{
    IDX_DEBUG_EVENT, IDX_DEBUG_CHANNEL, IDX_SYSTEM_EVENT, IDX_PORT_AND_CAN};
  // ==========================================================
  // implemented bits and reset values
  localparam logic [REG_W-1:0] PRIO_MASK [NUM_PRIO] = '{
    16'h3C00, 16'h003F, 16'hFFCF, 16'hFFFC};
  localparam logic [REG_W-1:0] RESET_PRIORITY = 16'h0000;
  localparam logic [VBA_W-1:0] RESET_VECTOR_BASE = 16'h0000;
  localparam logic [FIELD_W-1:0] FIELD_OFF = 2'h0;
  localparam logic [LVL_W-1:0] PERIPH_LEVEL_TOP = 2'h2;
  // ==========================================================
  // field placement per source: register number and low bit
  // order: breakpoint, step, rx, tx, trace, flash x3, pll, low voltage,
  // ext b, ext a, port d/e/f, can msg/wake/fault/bus off
  localparam int SRC_REG [NUM_SRC] = '{
    0, 0, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3, 3, 3, 3};
  localparam int SRC_LSB [NUM_SRC] = '{
    12, 10, 4, 2, 0, 14, 12, 10, 8, 6, 2, 0, 14, 12, 10, 8, 6, 4, 2};
  // ==========================================================
  // status word layout
  localparam int STAT_VEC_LSB = 0;
  localparam int STAT_LVL_LSB = 8;
  localparam int STAT_REQ_BIT = 12;
  // ==========================================================
  // field decode: {enable, level}; debug codes map 1..3, others 0..2
  function automatic logic [LVL_W:0] iplr_decode(input logic [FIELD_W-1:0] code,
                                                 input logic isDebug);
    logic [LVL_W:0] res;
    res = '0;
    if (code != FIELD_OFF) begin
      res[LVL_W] = 1'b1;
      res[LVL_W-1:0] = isDebug ? code : LVL_W'(code - 2'h1);
    end
    return res;
  endfunction : iplr_decode
endpackage : iplr_pkg

// ===== logic/iplr_arbiter.sv
// highest-level pending source picker
`timescale 1ns/1ns
`default_nettype none
module iplr_arbiter
  import iplr_pkg::*;
#(
  parameter int N = NUM_SRC
) (
  input wire logic [N-1:0] srcPending,
  input wire logic [N-1:0] srcEnable,
  input wire logic [2*N-1:0] srcLevel,
  output logic winValid,
  output logic [VEC_W-1:0] winIndex,
  output logic [LVL_W-1:0] winLevel
);
  // ==========================================================
  // scan: strictly higher level replaces, so ties go to the lower index
  always_comb begin
    winValid = 1'b0;
    winIndex = '0;
    winLevel = '0;
    for (int i = 0; i < N; i++) begin
      if (srcPending[i] && srcEnable[i]) begin
        if (!winValid || srcLevel[2*i +: 2] > winLevel) begin
          winValid = 1'b1;
          winIndex = VEC_W'(i);
          winLevel = srcLevel[2*i +: 2];
        end
      end
    end
  end
endmodule : iplr_arbiter
`default_nettype wire

// ===== sim/iplr_core_model.sv
// core stand-in that fetches the vector address of each request
`timescale 1ns/1ns
`default_nettype none
module iplr_core_model
  import iplr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic irqRequest,
  input wire logic [VBA_W+VEC_W-1:0] irqVectorAddr,
  output logic [VBA_W+VEC_W-1:0] fetchAddr_r
);
  // ========
  // fetch
  // no nesting mask here: that lives in the core, outside this block
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fetchAddr_r <= '0;
    end else if (irqRequest) begin
      fetchAddr_r <= irqVectorAddr;
    end
  end
endmodule : iplr_core_model
`default_nettype wire

// ===== sim/iplr_priority_regs_tb.sv
// self-checking bench for the priority level registers
`timescale 1ns/1ns
`default_nettype none
module iplr_priority_regs_tb
  import iplr_pkg::*;
();
  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] dIn = 32'h0;
  logic [NUM_SRC-1:0] pend = '0;
  logic [31:0] dOut;
  logic ack;
  logic irqRequest;
  logic [LVL_W-1:0] irqLevel;
  logic [VEC_W-1:0] irqVector;
  logic [VBA_W+VEC_W-1:0] irqVectorAddr;
  logic [VBA_W+VEC_W-1:0] fetchAddr;
  logic [VBA_W+VEC_W-1:0] expAddr;
  logic expReq;
  logic [15:0] expStat;
  logic [15:0] mdl [4] = '{16'h0, 16'h0, 16'h0, 16'h0};
  logic [15:0] vector_base = 16'h0;
  logic [31:0] seed = 32'h305797D9;
  logic [31:0] q;
  int numErrors = 0;
  int cmpCount = 0;

  always #50 ref_clk = ~ref_clk;

  iplr_priority_regs #(.ADR_W(8)) dut (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dIn),
    .wb_dat_o(dOut), .wb_ack_o(ack), .irqPending(pend), .irqRequest(irqRequest),
    .irqLevel(irqLevel), .irqVector(irqVector), .irqVectorAddr(irqVectorAddr));
  iplr_core_model core (.ref_clk(ref_clk), .resetn(resetn), .irqRequest(irqRequest),
    .irqVectorAddr(irqVectorAddr), .fetchAddr_r(fetchAddr));

  // ========
  // helpers
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmpCount++;
    if (g !== e) begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // one classic cycle; model updated at the ack edge only
  task automatic wb(input logic w, input logic [5:0] i, input logic [15:0] d);
    int n;
    logic [15:0] m;
    @(posedge ref_clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= {i, 2'h0};
    dIn <= {16'h0, d};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    q = dOut;
    cyc <= 1'h0;
    stb <= 1'h0;
    m = {{8{sel[1]}}, {8{sel[0]}}};
    if (w && i < 6'h04) mdl[i[1:0]] = (mdl[i[1:0]] & ~m) | (d & m & PRIO_MASK[i[1:0]]);
    if (w && i == IDX_VECTOR_BASE) vector_base = (vector_base & ~m) | (d & m);
    if (n >= 20) begin
      numErrors++;
      finishTest();
    end
  endtask : wb

  task automatic rdChk(input logic [5:0] i, input logic [15:0] e);
    wb(1'h0, i, 16'h0);
    chk("readData", {16'h0, e}, q);
  endtask : rdChk

  task automatic chkIrq();
    int best;
    int lv;
    int l;
    logic [1:0] c;
    best = -1;
    lv = -1;
    for (int i = 0; i < NUM_SRC; i++) begin
      c = mdl[SRC_REG[i]][SRC_LSB[i] +: 2];
      l = (i < NUM_DBG) ? int'(c) : int'(c) - 1;
      if (pend[i] && c != 2'h0 && l > lv) begin
        lv = l;
        best = i;
      end
    end
    expReq = (best >= 0);
    expAddr = {vector_base, 7'(best)};
    expStat = 16'h0;
    if (expReq) begin
      expStat = 16'((1 << STAT_REQ_BIT) | (lv << STAT_LVL_LSB) | (best << STAT_VEC_LSB));
    end
    chk("irqRequest", 32'(expReq), 32'(irqRequest));
    if (expReq) begin
      chk("irqLevel", 32'(lv), 32'(irqLevel));
      chk("irqVector", 32'(best), 32'(irqVector));
      chk("irqVectorAddr", 32'(expAddr), 32'(irqVectorAddr));
    end
  endtask : chkIrq

  task automatic rstChk();
    for (int i = 0; i < 4; i++) rdChk(6'(i), 16'h0);
    rdChk(IDX_VECTOR_BASE, 16'h0);
    #1;
    chkIrq();
  endtask : rstChk

  task finishTest();
    $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finishTest

  // ========
  // sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'h1;
    rstChk();
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      wb(1'h1, 6'(i), 16'(xs()));
      rdChk(6'(i), mdl[i]);
    end
    sel <= 4'h1;
    wb(1'h1, IDX_SYSTEM_EVENT, 16'hFFFF);
    rdChk(IDX_SYSTEM_EVENT, mdl[2]);
    sel <= 4'hF;
    wb(1'h1, 6'h05, 16'hFFFF);
    rdChk(6'h05, 16'h0);
    wb(1'h1, IDX_ARB_STATUS, 16'hFFFF);
    rdChk(IDX_ARB_STATUS, 16'h0);
    $display("register access done");
    // each code of each source, alone, checked one edge after the write
    for (int s = 0; s < NUM_SRC; s++) begin
      for (int c = 0; c < 4; c++) begin
        @(posedge ref_clk);
        pend <= NUM_SRC'(1) << s;
        wb(1'h1, 6'(SRC_REG[s]), 16'(c) << SRC_LSB[s]);
        @(posedge ref_clk);
        #1;
        chkIrq();
      end
    end
    $display("field decode done");
    for (int k = 0; k < 40; k++) begin
      @(posedge ref_clk);
      pend <= NUM_SRC'(xs());
      for (int i = 0; i < 4; i++) wb(1'h1, 6'(i), 16'(xs()));
      wb(1'h1, IDX_VECTOR_BASE, 16'(xs()));
      @(posedge ref_clk);
      #1;
      chkIrq();
      @(posedge ref_clk);
      #1;
      if (expReq) chk("fetchAddr", 32'(expAddr), 32'(fetchAddr));
      rdChk(IDX_ARB_STATUS, expStat);
    end
    $display("arbitration done");
    @(posedge ref_clk);
    resetn <= 1'h0;
    for (int i = 0; i < 4; i++) mdl[i] = 16'h0;
    vector_base = 16'h0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'h1;
    rstChk();
    $display("second reset done");
    finishTest();
  end
endmodule : iplr_priority_regs_tb
`default_nettype wire
